// *** design/rx_alarm_irq.v ***
// Receive alarm and error interrupt enable, status and request logic, AXI4-Lite slave.
// Assumes detector inputs are synchronous to aclk and framing errors come as pulses.
// Functional notes
// - Enable bits 7 to 5 are reserved: they read as zero and ignore writes.
// - Enable bit 3, zero at reset, lets a line code violation raise an interrupt.
// - Enable bit 2, zero at reset, lets both declaring and clearing frame loss interrupt.
// - Enable bit 1, zero at reset, lets both edges of the all-ones alarm interrupt.
// - Enable bit 0, zero at reset, lets both edges of the remote alarm interrupt.
// - Status bits latch events and clear when software reads the status register.
// - Remote alarm is declared after its pattern lasts 900 ms and cleared at once.
// - Frame loss is declared when a threshold of framing errors falls in a window.
//
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "rx_alarm_irq_defines.vh"
module rx_alarm_irq #(
    parameter [31:0] REMOTE_PERSIST_CYCLES = `REMOTE_PERSIST_CYCLES
) (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire line_code_err,
    input wire frame_bit_err,
    input wire all_ones_alarm,
    input wire remote_pattern,
    output reg irq
);
    function mapped;
        input [7:0] a;
        begin
            mapped = (a == `ENABLE_REG_OFFSET) || (a == `STATUS_REG_OFFSET) ||
                     (a == `MASK_REG_OFFSET) || (a == `STATE_REG_OFFSET) ||
                     (a == `THRESHOLD_REG_OFFSET);
        end
    endfunction

    reg [3:0] enable_reg;
    reg [3:0] status_reg;
    reg [3:0] mask_reg;
    reg [3:0] err_threshold_reg;
    reg [3:0] err_window_reg;
    reg [7:0] aw_addr_reg;
    reg aw_held_reg;
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;
    reg w_held_reg;
    reg frame_loss_reg;
    reg [3:0] win_pos_reg;
    reg [3:0] err_cnt_reg;
    reg frame_loss_prev_reg;
    reg all_ones_prev_reg;
    reg remote_prev_reg;
    wire remote_alarm;
    wire [3:0] events;
    wire do_write;
    wire rd_status;
    reg [31:0] rd_data;

    // Remote alarm needs persistence; 900 ms count is a parameter for simulation
    persist_detector #(
        .PERSIST_CYCLES(REMOTE_PERSIST_CYCLES)
    ) remote_det (
        .aclk(aclk),
        .aresetn(aresetn),
        .condition(remote_pattern),
        .declared(remote_alarm)
    );

    // Frame loss: threshold errors within a window of framing bits
    always @(posedge aclk) begin
        if (!aresetn) begin
            win_pos_reg <= 4'h0;
            err_cnt_reg <= 4'h0;
            frame_loss_reg <= 1'b0;
        end else if (frame_bit_err || win_pos_reg != 4'h0) begin
            if (err_threshold_reg != 4'h0 && err_cnt_reg + {3'b000, frame_bit_err} >=
                err_threshold_reg) begin
                frame_loss_reg <= 1'b1;
            end
            if (win_pos_reg >= err_window_reg) begin
                win_pos_reg <= 4'h0;
                err_cnt_reg <= 4'h0;
            end else begin
                win_pos_reg <= win_pos_reg + 4'h1;
                err_cnt_reg <= err_cnt_reg + {3'b000, frame_bit_err};
            end
        end else if (err_window_reg == 4'h0) begin
            frame_loss_reg <= 1'b0;
        end else begin
            // Reframes on the first error-free cycle after a window ends; limitation: no separate frame search
            frame_loss_reg <= frame_loss_reg & (err_cnt_reg != 4'h0);
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            frame_loss_prev_reg <= 1'b0;
            all_ones_prev_reg <= 1'b0;
            remote_prev_reg <= 1'b0;
        end else begin
            frame_loss_prev_reg <= frame_loss_reg;
            all_ones_prev_reg <= all_ones_alarm;
            remote_prev_reg <= remote_alarm;
        end
    end

    // Both edges count as a change
    assign events[`BIT_LINE_CODE] = line_code_err;
    assign events[`BIT_FRAME_LOSS] = frame_loss_reg ^ frame_loss_prev_reg;
    assign events[`BIT_ALL_ONES] = all_ones_alarm ^ all_ones_prev_reg;
    assign events[`BIT_REMOTE] = remote_alarm ^ remote_prev_reg;

    assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign rd_status = s_axi_arvalid && s_axi_arready && s_axi_araddr == `STATUS_REG_OFFSET;

    always @* begin
        rd_data = 32'h0000_0000;
        case (s_axi_araddr)
            `ENABLE_REG_OFFSET: rd_data = {28'h0000000, enable_reg};
            `STATUS_REG_OFFSET: rd_data = {28'h0000000, status_reg};
            `MASK_REG_OFFSET: rd_data = {28'h0000000, mask_reg};
            `STATE_REG_OFFSET: rd_data = {29'h00000000, frame_loss_reg, all_ones_alarm,
                                          remote_alarm};
            `THRESHOLD_REG_OFFSET: rd_data = {24'h000000, err_window_reg, err_threshold_reg};
            default: rd_data = 32'h0000_0000;
        endcase
    end

    // Write channel: address and data accepted in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            enable_reg <= `ENABLE_RESET;
            mask_reg <= `MASK_RESET;
            err_threshold_reg <= `THRESHOLD_RESET;
            err_window_reg <= `WINDOW_RESET;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_reg <= s_axi_awaddr;
                aw_held_reg <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
                w_held_reg <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(aw_addr_reg) ? `RESP_OKAY : `RESP_SLVERR;
                if (w_strb_reg[0]) begin
                    // Enable and mask bits 7 to 4 never stored: reserved and must-be-zero; threshold bits 7 to 4 hold the window
                    if (aw_addr_reg == `ENABLE_REG_OFFSET)
                        enable_reg <= w_data_reg[3:0];
                    if (aw_addr_reg == `MASK_REG_OFFSET)
                        mask_reg <= w_data_reg[3:0];
                    if (aw_addr_reg == `THRESHOLD_REG_OFFSET) begin
                        err_threshold_reg <= w_data_reg[3:0];
                        err_window_reg <= w_data_reg[7:4];
                    end
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Read channel and status; a new event in the read cycle survives the clear
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_OKAY;
            status_reg <= 4'h0;
            irq <= 1'b0;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_data;
                s_axi_rresp <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
            // Enable gates latching; W1C also honoured as an alternative clear
            status_reg <= (rd_status ? 4'h0 : status_reg &
                           ~((do_write && w_strb_reg[0] && aw_addr_reg == `STATUS_REG_OFFSET)
                             ? w_data_reg[3:0] : 4'h0)) | (events & enable_reg);
            irq <= |(status_reg & enable_reg & mask_reg);
        end
    end
endmodule
`default_nettype wire

// *** design/rx_alarm_irq_defines.vh ***
// Constants for the receive alarm interrupt block: offsets, fields, resets, timing.
// Assumes inclusion by bare name from design files.
`ifndef RX_ALARM_IRQ_DEFINES_VH
`define RX_ALARM_IRQ_DEFINES_VH
`define ENABLE_REG_OFFSET 8'h00
`define STATUS_REG_OFFSET 8'h04
`define MASK_REG_OFFSET 8'h08
`define STATE_REG_OFFSET 8'h0C
`define THRESHOLD_REG_OFFSET 8'h10
`define BIT_REMOTE 0
`define BIT_ALL_ONES 1
`define BIT_FRAME_LOSS 2
`define BIT_LINE_CODE 3
`define BIT_MUST_ZERO 4
`define ENABLE_RESET 4'h0
`define MASK_RESET 4'hF
`define THRESHOLD_RESET 4'h0
`define WINDOW_RESET 4'h0
`define CLOCK_HZ 50000000
`define REMOTE_PERSIST_MS 900
`define REMOTE_PERSIST_CYCLES ((`CLOCK_HZ / 1000) * `REMOTE_PERSIST_MS)
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// *** design/persist_detector.v ***
// Declares a condition after it persists for a count of cycles; clears at once.
// Assumes input synchronous to aclk.
`timescale 1ns/1ps
`default_nettype none
module persist_detector #(
    parameter [31:0] PERSIST_CYCLES = 32'd45000000
) (
    input wire aclk,
    input wire aresetn,
    input wire condition,
    output reg declared
);
    reg [31:0] count_reg;
    always @(posedge aclk) begin
        if (!aresetn) begin
            count_reg <= 32'h0000_0000;
            declared <= 1'b0;
        end else if (!condition) begin
            // Clear immediately when the pattern goes away
            count_reg <= 32'h0000_0000;
            declared <= 1'b0;
        end else if (count_reg >= PERSIST_CYCLES - 32'd1) begin
            declared <= 1'b1;
        end else begin
            count_reg <= count_reg + 32'd1;
        end
    end
endmodule
`default_nettype wire

// *** dv/rx_alarm_irq_checker.sv ***
// Port checker for the alarm interrupt block.
// Assumes write address and data are offered in the same cycle.
`timescale 1ns/1ps
`default_nettype none
`include "rx_alarm_irq_defines.vh"
module rx_alarm_irq_checker #(parameter [31:0] REMOTE_PERSIST_CYCLES = 32'd20) (
    input wire logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
    input wire logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid,
    input wire logic s_axi_arready, s_axi_rvalid, line_code_err, all_ones_alarm, irq,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb
);
    logic [3:0] en;
    logic [3:0] mk;
    wire aw = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire wr = aw && s_axi_wstrb[0];
    // Shadow copies, since the request timing depends on them
    always @(posedge aclk) begin
        if (!aresetn) begin
            en <= 4'h0;
            mk <= 4'hF;
        end else if (wr && s_axi_awaddr == `ENABLE_REG_OFFSET) begin
            en <= s_axi_wdata[3:0];
        end else if (wr && s_axi_awaddr == `MASK_REG_OFFSET) begin
            mk <= s_axi_wdata[3:0];
        end
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_reset_quiet: assert property ($rose(aresetn) |-> !irq && !s_axi_bvalid && !s_axi_rvalid)
        else $error("busy after reset");
    // Both parts are held one edge before the response is launched
    a_write_answer: assert property (aw |-> ##2 s_axi_bvalid) else $error("no bvalid");
    a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken early");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no rvalid");
    a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken early");
    a_code_err_irq: assert property (line_code_err && en[3] && mk[3] |-> ##[1:3] irq)
        else $error("code error no irq");
    a_ais_edge_irq: assert property ($changed(all_ones_alarm) && en[1] && mk[1] |-> ##[1:4] irq)
        else $error("all-ones edge no irq");
    a_idle_quiet: assert property ((en == 4'h0)[*3] |-> !irq)
        else $error("irq with nothing enabled");
    c_code_err: cover property (line_code_err && en[3]);
    c_irq_drop: cover property ($fell(irq));
    c_ais_edge: cover property ($changed(all_ones_alarm) && en[1]);
endmodule
bind rx_alarm_irq rx_alarm_irq_checker #(.REMOTE_PERSIST_CYCLES(REMOTE_PERSIST_CYCLES)) u_chk (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .line_code_err, .all_ones_alarm, .irq, .s_axi_awaddr, .s_axi_wdata, .s_axi_wstrb);
`default_nettype wire

// *** dv/alarm_source_model.sv ***
// Detector stand-in: error pulses and alarm levels on command.
// Assumes calls from the bench on the shared clock.
`timescale 1ns/1ps
`default_nettype none
module alarm_source_model (
    input wire logic aclk,
    output logic line_code_err = 1'b0,
    output logic frame_bit_err = 1'b0,
    output logic all_ones_alarm = 1'b0,
    output logic remote_pattern = 1'b0
);
    task automatic act(input int s, input logic v);
        begin
            @(posedge aclk);
            case (s)
                0: remote_pattern <= v;
                1: all_ones_alarm <= v;
                2: frame_bit_err <= v;
                default: line_code_err <= v;
            endcase
            // Errors last one cycle; a held line counts as many
            if (s > 1) @(posedge aclk);
            frame_bit_err <= 1'b0;
            line_code_err <= 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
// Bench: AXI4-Lite master, event table, then edge cases.
// Assumes the defines header is on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "rx_alarm_irq_defines.vh"
module tb_top;
    typedef struct packed {logic [3:0] en; int s; logic v; logic [3:0] ex;} row_t;
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_bready = 1'b1, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
    logic [3:0] s_axi_wstrb = 4'h1;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic line_code_err, frame_bit_err, all_ones_alarm, remote_pattern;
    int n_errors = 0, checks = 0;
    // Enable, source (0 remote, 1 all-ones, 2 framing, 3 code), level, status
    row_t rows[8] = '{'{4'h8, 3, 1'b1, 4'h8}, '{4'h0, 3, 1'b1, 4'h0}, '{4'h2, 1, 1'b1, 4'h2},
        '{4'h2, 1, 1'b0, 4'h2}, '{4'h1, 0, 1'b1, 4'h1}, '{4'h1, 0, 1'b0, 4'h1},
        '{4'h4, 2, 1'b1, 4'h4}, '{4'h8, 1, 1'b1, 4'h0}};
    rx_alarm_irq #(.REMOTE_PERSIST_CYCLES(32'd20)) DUT (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .line_code_err, .frame_bit_err, .all_ones_alarm, .remote_pattern, .irq);
    alarm_source_model src (.aclk, .line_code_err, .frame_bit_err, .all_ones_alarm,
        .remote_pattern);
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        rsp = s_axi_bresp;
    endtask
    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rdat = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        // One idle edge, so rready is never set twice in a step
        @(posedge aclk);
    endtask
    task automatic final_report;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        forever #10 aclk = ~aclk;
    end
    initial begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        final_report;
    end
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`ENABLE_REG_OFFSET);
        chk("enable_reset", rdat, 32'h0);
        wr(`THRESHOLD_REG_OFFSET, 32'h41);
        chk("bresp_ok", rsp, `RESP_OKAY);
        foreach (rows[i]) begin
            wr(`ENABLE_REG_OFFSET, {28'h0, rows[i].en});
            src.act(rows[i].s, rows[i].v);
            repeat (30) @(posedge aclk);
            chk("irq_set", irq, |rows[i].ex);
            rd(`STATUS_REG_OFFSET);
            chk("status", rdat, rows[i].ex);
            repeat (3) @(posedge aclk);
            chk("irq_clear", irq, 0);
        end
        // Bit 4 kept at zero by software; reserved bits written high
        wr(`ENABLE_REG_OFFSET, 32'hEF);
        rd(`ENABLE_REG_OFFSET);
        chk("reserved", rdat, 32'hF);
        wr(`ENABLE_REG_OFFSET, 32'h8);
        wr(`MASK_REG_OFFSET, 32'h0);
        src.act(3, 1'b1);
        repeat (5) @(posedge aclk);
        chk("irq_masked", irq, 0);
        wr(`MASK_REG_OFFSET, 32'hF);
        repeat (3) @(posedge aclk);
        chk("irq_unmasked", irq, 1);
        wr(`STATUS_REG_OFFSET, 32'h8);
        repeat (3) @(posedge aclk);
        chk("irq_w1c", irq, 0);
        wr(`ENABLE_REG_OFFSET, 32'h1);
        src.act(0, 1'b1);
        repeat (10) @(posedge aclk);
        src.act(0, 1'b0);
        rd(`STATUS_REG_OFFSET);
        chk("short_remote", rdat, 32'h0);
        rd(8'h14);
        chk("bad_rresp", rsp, `RESP_SLVERR);
        chk("bad_rdata", rdat, 32'h0);
        wr(8'h14, 32'h1);
        chk("bad_bresp", rsp, `RESP_SLVERR);
        // Mid-run reset must clear the enables written above
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`ENABLE_REG_OFFSET);
        chk("enable_rereset", rdat, 32'h0);
        chk("irq_rereset", irq, 0);
        final_report;
    end
endmodule
`default_nettype wire
